//--- core/iwcs_top.v
// Decided for this implementation: the register offsets and the Wishbone register port.
`default_nettype none
`include "iwcs_defines.vh"
module iwcs_top #(
  parameter NPER = 4
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  input  wire        we_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output wire [31:0] dat_o,
  output wire        ack_o,
  // Event sources
  input  wire        ext_irq_pin_i,
  input  wire [NPER-1:0] periph_evt_i,
  // Core sequencing
  input  wire        halt_exec_i,
  input  wire        core_step_i,
  input  wire        irq_return_i,
  input  wire [14:0] core_pc_i,
  // Live core context
  input  wire [7:0]  core_w_i,
  input  wire [7:0]  core_status_i,
  input  wire [4:0]  core_bank_i,
  input  wire [15:0] core_fsr0_i,
  input  wire [15:0] core_fsr1_i,
  input  wire [6:0]  core_pchi_i,
  // Core control
  output wire        halted_o,
  output wire        flush_o,
  output wire        idle_o,
  output wire        pc_load_o,
  output wire [14:0] pc_vector_o,
  output wire        stack_push_o,
  output wire [14:0] stack_push_pc_o,
  output wire        stack_pop_o,
  // Restored context
  output wire        restore_o,
  output wire [7:0]  rest_w_o,
  output wire [7:0]  rest_status_o,
  output wire [4:0]  rest_bank_o,
  output wire [15:0] rest_fsr0_o,
  output wire [15:0] rest_fsr1_o,
  output wire [6:0]  rest_pchi_o,
  // Interrupt
  output wire        irq_o
);
  localparam [2:0] ST_RUN   = 3'd0;
  localparam [2:0] ST_HALT  = 3'd1;
  localparam [2:0] ST_WAKE  = 3'd2;
  localparam [2:0] ST_IDLE1 = 3'd3;
  localparam [2:0] ST_IDLE2 = 3'd4;

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg        glb_en_reg;
  reg        edge_sel_reg;
  reg [4:0]  en0_reg;
  reg [4:0]  flag0_reg;
  reg [3:0]  evt_stat_reg;
  reg [3:0]  evt_en_reg;
  reg        ack_reg;
  reg [31:0] dat_reg;
  reg        halted_reg;
  reg        flush_reg;
  reg        idle_reg;
  reg        pc_load_reg;
  reg        push_reg;
  reg [14:0] push_pc_reg;
  reg        pop_reg;
  reg        restore_reg;
  reg [63:0] rest_reg;
  reg        irq_reg;

  wire        ext_edge;
  wire [63:0] shadow;
  wire [63:0] live_ctx;
  wire        acc;
  wire        wr;
  wire        wr_ok;
  wire        in_shd;
  wire [4:0]  evt_set;
  wire [4:0]  pend;
  wire        any_pend;
  wire        go_entry;
  wire        go_exit;
  wire [3:0]  evt_hit;
  reg  [31:0] rdata;

  assign acc    = cyc_i & stb_i & ~ack_reg;
  assign wr     = acc & we_i;
  // Only the low byte lane carries register data
  assign wr_ok  = wr & sel_i[0];
  assign in_shd = (adr_i[7:5] == 3'b100) && (adr_i[1:0] == 2'b00);

  iwcs_pin_sync u_sync (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (ext_irq_pin_i),
    .rise_sel_i (edge_sel_reg),
    .edge_o     (ext_edge)
  );

  // Timeout and powerdown bits are not shadowed
  assign live_ctx = {1'b0, core_pchi_i, core_fsr1_i, core_fsr0_i, 3'b000, core_bank_i,
                     core_status_i & `IWCS_STATUS_SAVE, core_w_i};

  iwcs_shadow u_shadow (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .save_i   (go_entry),
    .live_i   (live_ctx),
    .wr_i     (wr_ok & in_shd),
    .idx_i    (adr_i[4:2]),
    .wdata_i  (dat_i[7:0]),
    .shadow_o (shadow)
  );

  // Flags record events whatever the enables
  assign evt_set  = {ext_edge, periph_evt_i[3:0]};
  assign pend     = flag0_reg & en0_reg;
  assign any_pend = |pend;
  // Redirect only on flag with its enable and global enable
  assign go_entry = (state_reg == ST_RUN && glb_en_reg && any_pend && !halt_exec_i && !irq_return_i) ||
                    (state_reg == ST_WAKE && core_step_i && glb_en_reg);
  assign go_exit  = (state_reg == ST_RUN) && irq_return_i;
  assign evt_hit  = {go_exit, go_entry, (state_reg == ST_HALT) && any_pend, ext_edge};

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (halt_exec_i) begin
          // Pending enabled source makes the halt a no-op
          state_next = any_pend ? ST_WAKE : ST_HALT;
        end else if (go_entry) begin
          state_next = ST_IDLE1;
        end
      end
      ST_HALT: begin
        // Waking needs the source enable only, not global enable
        if (any_pend) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // One instruction after the halt runs before any branch
        if (core_step_i) begin
          state_next = glb_en_reg ? ST_IDLE1 : ST_RUN;
        end
      end
      ST_IDLE1: begin
        state_next = ST_IDLE2;
      end
      ST_IDLE2: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Control, enable and flag registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      glb_en_reg   <= 1'b0;
      edge_sel_reg <= 1'b0;
      en0_reg      <= 5'h00;
      flag0_reg    <= 5'h00;
      evt_en_reg   <= 4'h0;
    end else begin
      if (go_entry) begin
        glb_en_reg <= 1'b0;
      end else if (go_exit) begin
        glb_en_reg <= 1'b1;
      end else if (wr_ok && adr_i == `IWCS_ADR_CTRL) begin
        glb_en_reg <= dat_i[`IWCS_CTRL_GLB_EN];
      end
      if (wr_ok && adr_i == `IWCS_ADR_CTRL) begin
        edge_sel_reg <= dat_i[`IWCS_CTRL_EDGE];
      end
      if (wr_ok && adr_i == `IWCS_ADR_EN0) begin
        en0_reg <= dat_i[4:0];
      end
      if (wr_ok && adr_i == `IWCS_ADR_EVT_EN) begin
        evt_en_reg <= dat_i[3:0];
      end
      // Hardware set wins over a software write in the same cycle
      if (wr_ok && adr_i == `IWCS_ADR_FLAG0) begin
        flag0_reg <= dat_i[4:0] | evt_set;
      end else begin
        flag0_reg <= flag0_reg | evt_set;
      end
    end
  end

  // Sticky event status, write-one-to-clear, set wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      evt_stat_reg <= 4'h0;
      irq_reg      <= 1'b0;
    end else begin
      if (wr_ok && adr_i == `IWCS_ADR_EVT_CLR) begin
        evt_stat_reg <= (evt_stat_reg & ~dat_i[3:0]) | evt_hit;
      end else begin
        evt_stat_reg <= evt_stat_reg | evt_hit;
      end
      irq_reg <= |(evt_stat_reg & evt_en_reg);
    end
  end

  // Core sequencing outputs, all one-cycle pulses except halted and idle
  always @(posedge clk_i) begin
    if (rst_i) begin
      halted_reg  <= 1'b0;
      flush_reg   <= 1'b0;
      idle_reg    <= 1'b0;
      pc_load_reg <= 1'b0;
      push_reg    <= 1'b0;
      push_pc_reg <= 15'h0000;
      pop_reg     <= 1'b0;
      restore_reg <= 1'b0;
      rest_reg    <= 64'h0000_0000_0000_0000;
    end else begin
      halted_reg  <= (state_next == ST_HALT);
      flush_reg   <= go_entry;
      pc_load_reg <= go_entry;
      push_reg    <= go_entry;
      // Idle covers the flushed slot and the vector fetch
      idle_reg    <= (state_next == ST_IDLE1) || (state_next == ST_IDLE2);
      if (go_entry) begin
        push_pc_reg <= core_pc_i;
      end
      pop_reg     <= go_exit;
      restore_reg <= go_exit;
      if (go_exit) begin
        // Shadow values, possibly edited by software, replace live ones
        rest_reg <= shadow;
      end
    end
  end

  // Wishbone read mux, unmapped reads return zero
  always @* begin
    rdata = 32'h0000_0000;
    if (in_shd) begin
      rdata = {24'h000000, shadow[adr_i[4:2]*8 +: 8]};
    end else begin
      case (adr_i)
        `IWCS_ADR_CTRL:     rdata = {24'h000000, glb_en_reg, 6'h00, edge_sel_reg};
        `IWCS_ADR_EN0:      rdata = {27'h0000000, en0_reg};
        `IWCS_ADR_FLAG0:    rdata = {27'h0000000, flag0_reg};
        `IWCS_ADR_EVT_STAT: rdata = {28'h0000000, evt_stat_reg};
        `IWCS_ADR_EVT_EN:   rdata = {28'h0000000, evt_en_reg};
        default:            rdata = 32'h0000_0000;
      endcase
    end
  end

  // Every access, mapped or not, is acked one cycle later
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= acc;
      if (acc && !we_i) begin
        dat_reg <= rdata;
      end
    end
  end

  assign dat_o           = dat_reg;
  assign ack_o           = ack_reg;
  assign halted_o        = halted_reg;
  assign flush_o         = flush_reg;
  assign idle_o          = idle_reg;
  assign pc_load_o       = pc_load_reg;
  assign pc_vector_o     = `IWCS_VECTOR;
  assign stack_push_o    = push_reg;
  assign stack_push_pc_o = push_pc_reg;
  assign stack_pop_o     = pop_reg;
  assign restore_o       = restore_reg;
  assign rest_w_o        = rest_reg[7:0];
  assign rest_status_o   = rest_reg[15:8];
  assign rest_bank_o     = rest_reg[20:16];
  assign rest_fsr0_o     = {rest_reg[39:32], rest_reg[31:24]};
  assign rest_fsr1_o     = {rest_reg[55:48], rest_reg[47:40]};
  assign rest_pchi_o     = rest_reg[62:56];
  assign irq_o           = irq_reg;
endmodule
`default_nettype wire

//--- core/iwcs_defines.vh
`ifndef IWCS_DEFINES_VH
`define IWCS_DEFINES_VH
// Register byte offsets
`define IWCS_ADR_CTRL     8'h00
`define IWCS_ADR_EN0      8'h04
`define IWCS_ADR_FLAG0    8'h08
`define IWCS_ADR_EVT_STAT 8'h0C
`define IWCS_ADR_EVT_CLR  8'h10
`define IWCS_ADR_EVT_EN   8'h14
// Shadow bank (bank 31) window, eight byte entries
`define IWCS_ADR_SHD_BASE 8'h80
`define IWCS_SHD_W        3'h0
`define IWCS_SHD_STATUS   3'h1
`define IWCS_SHD_BANK_SEL 3'h2
`define IWCS_SHD_FSR0L    3'h3
`define IWCS_SHD_FSR0H    3'h4
`define IWCS_SHD_FSR1L    3'h5
`define IWCS_SHD_FSR1H    3'h6
`define IWCS_SHD_PC_HIGH  3'h7
`define IWCS_SHD_BANK     5'h1F
// Field positions
`define IWCS_CTRL_GLB_EN  7
`define IWCS_CTRL_EDGE    0
`define IWCS_EXT_BIT      4
`define IWCS_STATUS_TMO   4
`define IWCS_STATUS_PWRDN 3
`define IWCS_STATUS_SAVE  8'hE7
// Event status bits
`define IWCS_EVT_EDGE     0
`define IWCS_EVT_WAKE     1
`define IWCS_EVT_ENTRY    2
`define IWCS_EVT_EXIT     3
// Vector and timing
`define IWCS_VECTOR       15'h0004
`define IWCS_ENTRY_IDLE   2
`endif

//--- core/iwcs_pin_sync.v
`default_nettype none
module iwcs_pin_sync (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Pin and edge choice
  input  wire pin_i,
  input  wire rise_sel_i,
  // Selected edge, one cycle
  output wire edge_o
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;
  reg edge_reg;
  reg [2:0] warm_reg;
  // Pin is asynchronous; only sync_reg reads meta_reg
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      edge_reg <= 1'b0;
      warm_reg <= 3'h0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      warm_reg <= {warm_reg[1:0], 1'b1};
      // No edge until prev_reg holds a synced level, whatever the pin idles at
      edge_reg <= warm_reg[2] & (rise_sel_i ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg));
    end
  end
  assign edge_o = edge_reg;
endmodule
`default_nettype wire

//--- core/iwcs_shadow.v
`default_nettype none
`include "iwcs_defines.vh"
module iwcs_shadow (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Save of live context
  input  wire        save_i,
  input  wire [63:0] live_i,
  // Software access
  input  wire        wr_i,
  input  wire [2:0]  idx_i,
  input  wire [7:0]  wdata_i,
  // Shadow contents
  output wire [63:0] shadow_o
);
  reg [7:0] mem_reg [0:7];
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ent
      // Entry save beats a software write in the same cycle
      always @(posedge clk_i) begin
        if (rst_i) begin
          mem_reg[g] <= 8'h00;
        end else if (save_i) begin
          mem_reg[g] <= live_i[g*8 +: 8];
        end else if (wr_i && idx_i == g) begin
          mem_reg[g] <= wdata_i;
        end
      end
      assign shadow_o[g*8 +: 8] = mem_reg[g];
    end
  endgenerate
endmodule
`default_nettype wire

//--- dv/iwcs_core_model.sv
`default_nettype none
module iwcs_core_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Device status
  input  wire logic halted_i,
  // Core progress
  output var  logic core_step_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_reg;
  logic       was_halted_reg;
  // Slow core: the instruction after halt finishes four cycles after wake
  always @(posedge clk_i) begin
    was_halted_reg <= halted_i;
    core_step_o    <= (cnt_reg == 2'h1);
    if (rst_i)
      cnt_reg <= 2'h0;
    else if (was_halted_reg && !halted_i)
      cnt_reg <= 2'h3;
    else if (cnt_reg != 2'h0)
      cnt_reg <= cnt_reg - 2'h1;
  end
endmodule
`default_nettype wire

//--- dv/iwcs_top_properties.sv
`default_nettype none
module iwcs_top_properties (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Observed ports
  input wire logic        irq_return_i,
  input wire logic [14:0] core_pc_i,
  input wire logic        flush_o,
  input wire logic        idle_o,
  input wire logic        pc_load_o,
  input wire logic [14:0] pc_vector_o,
  input wire logic        stack_push_o,
  input wire logic [14:0] stack_push_pc_o,
  input wire logic        stack_pop_o,
  input wire logic        restore_o,
  input wire logic [7:0]  rest_status_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  entry_group_a: assert property (
    flush_o |-> pc_load_o && stack_push_o && idle_o) else $error("entry pulses apart");
  entry_once_a: assert property (
    flush_o |=> !flush_o && !pc_load_o && !stack_push_o) else $error("entry pulse too long");
  idle_span_a: assert property (
    $rose(idle_o) |-> flush_o ##1 (idle_o && !flush_o) ##1 !idle_o) else $error("idle span wrong");
  vector_value_a: assert property (
    pc_load_o |-> pc_vector_o == 15'h0004) else $error("bad vector");
  push_pc_a: assert property (
    stack_push_o |-> stack_push_pc_o == $past(core_pc_i)) else $error("bad pushed pc");
  status_mask_a: assert property (
    restore_o |-> rest_status_o[4:3] == 2'h0) else $error("status flags restored");
  return_pop_a: assert property (
    stack_pop_o |-> restore_o && $past(irq_return_i)) else $error("pop without return");
  restore_pair_a: assert property (
    restore_o |-> stack_pop_o && !flush_o) else $error("restore without pop");
endmodule
bind iwcs_top iwcs_top_properties iwcs_top_properties_inst (
  .clk_i, .rst_i, .irq_return_i, .core_pc_i, .flush_o, .idle_o, .pc_load_o, .pc_vector_o,
  .stack_push_o, .stack_push_pc_o, .stack_pop_o, .restore_o, .rest_status_o
);
`default_nettype wire

//--- dv/tb_irq_wake_extpin_context_save.sv
`default_nettype none
module tb_irq_wake_extpin_context_save;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ext_irq_pin_i, halt_exec_i, core_step_i, irq_return_i;
  logic [7:0]  adr_i, core_w_i, core_status_i, rest_w_o, rest_status_o;
  logic [31:0] dat_i, dat_o;
  logic [3:0]  sel_i, periph_evt_i;
  logic [14:0] core_pc_i, pc_vector_o, stack_push_pc_o;
  logic [4:0]  core_bank_i, rest_bank_o;
  logic [15:0] core_fsr0_i, core_fsr1_i, rest_fsr0_o, rest_fsr1_o;
  logic [6:0]  core_pchi_i, rest_pchi_o;
  logic        ack_o, halted_o, flush_o, idle_o, pc_load_o, stack_push_o, stack_pop_o, restore_o, irq_o;
  int          fails, checks_done, flush_cnt;

  iwcs_top #(.NPER(4)) iwcs_top_inst (
    .clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o,
    .ext_irq_pin_i, .periph_evt_i, .halt_exec_i, .core_step_i, .irq_return_i, .core_pc_i,
    .core_w_i, .core_status_i, .core_bank_i, .core_fsr0_i, .core_fsr1_i, .core_pchi_i,
    .halted_o, .flush_o, .idle_o, .pc_load_o, .pc_vector_o, .stack_push_o, .stack_push_pc_o,
    .stack_pop_o, .restore_o, .rest_w_o, .rest_status_o, .rest_bank_o, .rest_fsr0_o,
    .rest_fsr1_o, .rest_pchi_o, .irq_o
  );
  iwcs_core_model iwcs_core_model_inst (.clk_i, .rst_i, .halted_i(halted_o), .core_step_o(core_step_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (flush_o === 1'b1) flush_cnt++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Ack is read as it stood before each edge; the master waits for it however long
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
    adr_i <= a;
    we_i  <= w;
    dat_i <= {24'h000000, d};
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  task automatic pin(input logic v);
    ext_irq_pin_i <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic entry_seen;
    int n;
    n = 0;
    while (flush_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk(flush_o, 1);
    chk(pc_load_o, 1);
    chk(stack_push_pc_o, core_pc_i);
  endtask
  task automatic halt_wake;
    halt_exec_i <= 1'b1;
    @(posedge clk_i);
    halt_exec_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(halted_o, 1);
    periph_evt_i <= 4'h1;
    @(posedge clk_i);
    periph_evt_i <= 4'h0;
    repeat (3) @(posedge clk_i);
    chk(halted_o, 0);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    wrap_up();
  end

  initial begin
    {adr_i, dat_i, we_i, cyc_i, stb_i, ext_irq_pin_i, periph_evt_i, halt_exec_i, irq_return_i} = '0;
    sel_i = 4'hF;
    {core_pc_i, core_w_i, core_status_i, core_bank_i} = {15'h1234, 8'hA5, 8'hFF, 5'h0B};
    {core_fsr0_i, core_fsr1_i, core_pchi_i} = {16'hBEEF, 16'h1357, 7'h2A};
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 0);
    rd(8'h04, 0);
    rd(8'h40, 0);
    wr(8'h00, 8'h01);
    pin(1'b1);
    rd(8'h08, 8'h10);
    wr(8'h08, 8'h00);
    pin(1'b0);
    rd(8'h08, 8'h00);
    wr(8'h00, 8'h00);
    pin(1'b1);
    rd(8'h08, 8'h00);
    pin(1'b0);
    rd(8'h08, 8'h10);
    rd(8'h0C, 8'h01);
    chk(irq_o, 0);
    wr(8'h14, 8'h01);
    wr(8'h0C, 8'h00);
    chk(irq_o, 1);
    rd(8'h0C, 8'h01);
    wr(8'h10, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0);
    wr(8'h80, 8'h3C);
    rd(8'h80, 8'h3C);
    // Entry through the pin with its source enable and the global enable set
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h10);
    wr(8'h00, 8'h81);
    ext_irq_pin_i <= 1'b1;
    entry_seen();
    rd(8'h00, 8'h01);
    rd(8'h80, 8'hA5);
    rd(8'h84, 8'hE7);
    rd(8'h98, 8'h13);
    rd(8'h9C, 8'h2A);
    wr(8'h80, 8'h5A);
    core_w_i <= 8'h00;
    wr(8'h08, 8'h00);
    irq_return_i <= 1'b1;
    @(posedge clk_i);
    irq_return_i <= 1'b0;
    @(posedge clk_i);
    chk(stack_pop_o, 1);
    chk(rest_w_o, 8'h5A);
    chk(rest_status_o, 8'hE7);
    chk(rest_fsr0_o, 16'hBEEF);
    chk(rest_fsr1_o, 16'h1357);
    chk(rest_bank_o, 5'h0B);
    chk(rest_pchi_o, 7'h2A);
    rd(8'h00, 8'h81);
    rd(8'h0C, 8'h0D);
    // Wake without the global enable resumes execution; with it, entry follows the step
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h01);
    chk(flush_cnt, 1);
    halt_wake();
    repeat (6) @(posedge clk_i);
    chk(flush_cnt, 1);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h81);
    halt_wake();
    repeat (2) @(posedge clk_i);
    chk(flush_cnt, 1);
    entry_seen();
    // Reset in mid-run must drop the enables set above
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h04, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h00, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
